// *** fsk_pkg.sv ***
// Shared constants for the profile / modulation control link and both of its ends.
// Assumes both ends run on a 250 MHz clk; the serial link is built from plain wires.
package fsk_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int WORD_BITS = 24;
   localparam int NUM_W = 24;
   localparam int DEV_COUNT = 8;
   localparam int AUDIO_BITS = 16;
   localparam int SYNC_W = 9;
   // Synchroniser contents after reset: every pin at its idle level, latch line high
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 9'h040;

   // Serial register addresses
   localparam logic [7:0] ADDR_MAIN = 8'h00;
   localparam logic [7:0] ADDR_NUM_A_HI = 8'h01;
   localparam logic [7:0] ADDR_NUM_A_LO = 8'h02;
   localparam logic [7:0] ADDR_DEV_B0 = 8'h09;
   localparam logic [7:0] ADDR_NUM_B_HI = 8'h17;
   localparam logic [7:0] ADDR_NUM_B_LO = 8'h18;
   localparam logic [7:0] ADDR_DEV_A0 = 8'h19;
   localparam logic [7:0] ADDR_DIRECT = 8'h21;
   localparam logic [7:0] ADDR_DEV_SEL = 8'h22;
   localparam logic [7:0] ADDR_MOD_CTRL = 8'h23;

   // Main control field positions and reset
   localparam int BIT_RESET = 13;
   localparam int BIT_TXRX_SRC = 11;
   localparam int BIT_POL = 10;
   localparam int BIT_RECAL = 9;
   localparam int BIT_PSW_SRC = 8;
   localparam int BIT_DUAL_CAL = 7;
   localparam int BIT_PSEL = 6;
   localparam int RSVD_LSB = 1;
   localparam int BIT_CAL_EN = 0;
   localparam logic [15:0] MAIN_RESET = 16'h0003;

   // Modulation control field positions and reset
   localparam int MC_MODE_LO = 0;
   localparam int MC_MODE_HI = 1;
   localparam int MC_LEVEL_LSB = 2;
   localparam int MC_A_EN = 4;
   localparam int MC_B_EN = 5;
   localparam logic [15:0] MOD_CTRL_RESET = 16'h0000;

   // Link timing: half period of the host-made serial clocks
   localparam int CLK_PERIOD_NS = 4;
   localparam int LINK_HALF_NS = 40;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {MODE_PIN, MODE_SELECT, MODE_AUDIO, MODE_DIRECT} mod_mode_t;
endpackage

// *** fsk_link_if.sv ***
// Wires between the host controller and the synthesizer control logic.
// All signals are driven from flip-flops in the host and sampled by the device.
`timescale 1ns/100ps
interface fsk_link_if;
   logic ser_clk;
   logic ser_data;
   logic ser_latch_n;
   logic txrx_control_pin;
   logic [2:0] mod_data_pin;
   logic mod_clk;
   logic mod_frame;

   modport device (
      input ser_clk,
      input ser_data,
      input ser_latch_n,
      input txrx_control_pin,
      input mod_data_pin,
      input mod_clk,
      input mod_frame
   );

   modport host (
      output ser_clk,
      output ser_data,
      output ser_latch_n,
      output txrx_control_pin,
      output mod_data_pin,
      output mod_clk,
      output mod_frame
   );
endinterface

// *** fsk_profile_control.sv ***
// Device end: serial register port, profile switching and modulation deviation.
// Assumes the link pins come from another clock domain and are resynchronised here.
`timescale 1ns/100ps
module fsk_profile_control
   import fsk_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   fsk_link_if.device link,
   output logic [NUM_W-1:0] freq_numerator,
   output logic active_profile,
   output logic transmit_active,
   output logic receive_active,
   output logic cal_start,
   output logic cal_dual,
   output logic [DATA_W-1:0] main_control
);

   function automatic logic [NUM_W-1:0] sign_extend(input logic [DATA_W-1:0] d);
      return {{(NUM_W-DATA_W){d[DATA_W-1]}}, d};
   endfunction

   // Index masked down to the programmed number of levels, eight at most
   function automatic logic [2:0] level_index(input logic [2:0] idx, input logic [1:0] lvl);
      logic [2:0] mask;
      case (lvl)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         default: mask = 3'h7;
      endcase
      return idx & mask;
   endfunction

   // Pin synchronisers: sync1 feeds only sync2
   logic [SYNC_W-1:0] sync1, sync2, sync3;
   logic s_ser_clk, s_ser_data, s_latch_n, s_txrx, s_mod_clk, s_mod_frame;
   logic [2:0] s_mod_data;
   logic p_ser_clk, p_latch_n, p_txrx, p_mod_clk, p_mod_frame;

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1 <= SYNC_IDLE;
         sync2 <= SYNC_IDLE;
         sync3 <= SYNC_IDLE;
      end else begin
         sync1 <= {link.ser_clk, link.ser_data, link.ser_latch_n, link.txrx_control_pin,
                   link.mod_clk, link.mod_frame, link.mod_data_pin};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign {s_ser_clk, s_ser_data, s_latch_n, s_txrx, s_mod_clk, s_mod_frame, s_mod_data} = sync2;
   assign {p_ser_clk, p_latch_n, p_txrx, p_mod_clk, p_mod_frame} =
      {sync3[8], sync3[6], sync3[5], sync3[4], sync3[3]};

   logic ser_rise, latch_rise, txrx_edge, mod_rise, frame_fall;
   assign ser_rise = s_ser_clk & ~p_ser_clk;
   assign latch_rise = s_latch_n & ~p_latch_n;
   assign txrx_edge = s_txrx ^ p_txrx;
   assign mod_rise = s_mod_clk & ~p_mod_clk;
   assign frame_fall = ~s_mod_frame & p_mod_frame;

   // Register state
   logic [WORD_BITS-1:0] shifter, next_shifter;
   logic [DATA_W-1:0] next_main_control, mod_ctrl, next_mod_ctrl;
   logic [NUM_W-1:0] num_a, next_num_a, num_b, next_num_b;
   logic [DATA_W-1:0] dev_a [DEV_COUNT];
   logic [DATA_W-1:0] dev_b [DEV_COUNT];
   logic [DATA_W-1:0] next_dev_a [DEV_COUNT];
   logic [DATA_W-1:0] next_dev_b [DEV_COUNT];
   logic [2:0] dev_sel, next_dev_sel;
   logic [DATA_W-1:0] direct_dev, next_direct_dev;
   logic [AUDIO_BITS-1:0] audio_shift, next_audio_shift, audio_dev, next_audio_dev;
   logic next_active_profile, next_cal_start, next_cal_dual;
   logic calibrated, next_calibrated;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic wr_main;

   assign wr_addr = shifter[WORD_BITS-1:DATA_W];
   assign wr_data = shifter[DATA_W-1:0];
   assign wr_main = latch_rise && wr_addr == ADDR_MAIN;

   always_comb begin
      next_shifter = shifter;
      next_main_control = main_control;
      next_mod_ctrl = mod_ctrl;
      next_num_a = num_a;
      next_num_b = num_b;
      next_dev_a = dev_a;
      next_dev_b = dev_b;
      next_dev_sel = dev_sel;
      next_direct_dev = direct_dev;
      next_audio_shift = audio_shift;
      next_audio_dev = audio_dev;
      next_active_profile = active_profile;
      next_cal_start = 1'b0;
      next_cal_dual = 1'b0;
      next_calibrated = calibrated;

      // Bits are taken only while the latch line is low; MSB first
      if (ser_rise && !s_latch_n) begin
         next_shifter = {shifter[WORD_BITS-2:0], s_ser_data};
      end

      if (mod_rise && s_mod_frame) begin
         next_audio_shift = {audio_shift[AUDIO_BITS-2:0], s_mod_data[0]};
      end
      // The word takes effect only once the frame closes, so a half-shifted
      // value never reaches the numerator
      if (frame_fall) begin
         next_audio_dev = audio_shift;
      end

      // Pin-driven swap needs both source bit and dual calibration enabled
      if (txrx_edge && main_control[BIT_PSW_SRC] && main_control[BIT_DUAL_CAL]) begin
         next_active_profile = ~active_profile;
      end

      if (latch_rise) begin
         if (wr_addr >= ADDR_DEV_A0 && wr_addr < ADDR_DEV_A0 + 8'(DEV_COUNT)) begin
            next_dev_a[3'(wr_addr - ADDR_DEV_A0)] = wr_data;
         end
         if (wr_addr >= ADDR_DEV_B0 && wr_addr < ADDR_DEV_B0 + 8'(DEV_COUNT)) begin
            next_dev_b[3'(wr_addr - ADDR_DEV_B0)] = wr_data;
         end
         case (wr_addr)
            ADDR_NUM_A_HI: next_num_a[NUM_W-1:DATA_W] = wr_data[7:0];
            ADDR_NUM_A_LO: next_num_a[DATA_W-1:0] = wr_data;
            ADDR_NUM_B_HI: next_num_b[NUM_W-1:DATA_W] = wr_data[7:0];
            ADDR_NUM_B_LO: next_num_b[DATA_W-1:0] = wr_data;
            ADDR_DIRECT: next_direct_dev = wr_data;
            ADDR_DEV_SEL: next_dev_sel = wr_data[2:0];
            ADDR_MOD_CTRL: next_mod_ctrl = wr_data;
            default: begin
            end
         endcase
      end

      if (wr_main) begin
         if (wr_data[BIT_RESET]) begin
            // Bit is never stored, so it reads back as zero
            next_main_control = MAIN_RESET;
            next_mod_ctrl = MOD_CTRL_RESET;
            next_num_a = '0;
            next_num_b = '0;
            next_dev_sel = '0;
            next_direct_dev = '0;
            next_active_profile = 1'b0;
            next_calibrated = 1'b0;
            for (int i = 0; i < DEV_COUNT; i++) begin
               next_dev_a[i] = '0;
               next_dev_b[i] = '0;
            end
         end else begin
            next_main_control = wr_data;
            next_active_profile = wr_data[BIT_PSEL];
            if (wr_data[BIT_CAL_EN]) begin
               next_cal_start = 1'b1;
               next_calibrated = 1'b1;
               // Both profiles on the first calibration when dual calibration is enabled, else only on request
               next_cal_dual = wr_data[BIT_RECAL] ||
                               (wr_data[BIT_DUAL_CAL] && !calibrated);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shifter <= '0;
         main_control <= MAIN_RESET;
         mod_ctrl <= MOD_CTRL_RESET;
         num_a <= '0;
         num_b <= '0;
         dev_sel <= '0;
         direct_dev <= '0;
         audio_shift <= '0;
         audio_dev <= '0;
         active_profile <= 1'b0;
         cal_start <= 1'b0;
         cal_dual <= 1'b0;
         calibrated <= 1'b0;
         for (int i = 0; i < DEV_COUNT; i++) begin
            dev_a[i] <= '0;
            dev_b[i] <= '0;
         end
      end else begin
         shifter <= next_shifter;
         main_control <= next_main_control;
         mod_ctrl <= next_mod_ctrl;
         num_a <= next_num_a;
         num_b <= next_num_b;
         dev_sel <= next_dev_sel;
         direct_dev <= next_direct_dev;
         audio_shift <= next_audio_shift;
         audio_dev <= next_audio_dev;
         active_profile <= next_active_profile;
         cal_start <= next_cal_start;
         cal_dual <= next_cal_dual;
         calibrated <= next_calibrated;
         dev_a <= next_dev_a;
         dev_b <= next_dev_b;
      end
   end

   // Deviation path and port switching
   mod_mode_t mode;
   logic [1:0] level;
   logic mod_enable;
   logic [2:0] index;
   logic [DATA_W-1:0] deviation;
   logic [NUM_W-1:0] base_num, next_freq_numerator;
   logic tx_level, next_transmit_active, next_receive_active;

   always_comb begin
      case ({mod_ctrl[MC_MODE_HI], mod_ctrl[MC_MODE_LO]})
         2'b00: mode = MODE_PIN;
         2'b01: mode = MODE_SELECT;
         2'b10: mode = MODE_AUDIO;
         default: mode = MODE_DIRECT;
      endcase
      level = mod_ctrl[MC_LEVEL_LSB +: 2];
      mod_enable = active_profile ? mod_ctrl[MC_B_EN] : mod_ctrl[MC_A_EN];
      base_num = active_profile ? num_b : num_a;
      index = '0;
      deviation = '0;
      case (mode)
         MODE_PIN: index = level_index(s_mod_data, level);
         MODE_SELECT: index = level_index(dev_sel, level);
         default: index = '0;
      endcase
      case (mode)
         MODE_PIN, MODE_SELECT: deviation = active_profile ? dev_b[index] : dev_a[index];
         MODE_DIRECT: deviation = direct_dev;
         MODE_AUDIO: deviation = AUDIO_BITS'(audio_dev);
         default: deviation = '0;
      endcase
      if (!mod_enable) begin
         deviation = '0;
      end
      // One count of numerator is one minimum step; sum wraps at 24 bits
      next_freq_numerator = NUM_W'(base_num + sign_extend(deviation));

      tx_level = main_control[BIT_POL] ? s_txrx : ~s_txrx;
      if (main_control[BIT_TXRX_SRC]) begin
         next_transmit_active = tx_level;
         next_receive_active = ~tx_level;
      end else begin
         // Register-controlled: the transmit port is the one left on
         next_transmit_active = 1'b1;
         next_receive_active = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         freq_numerator <= '0;
         transmit_active <= 1'b1;
         receive_active <= 1'b0;
      end else begin
         freq_numerator <= next_freq_numerator;
         transmit_active <= next_transmit_active;
         receive_active <= next_receive_active;
      end
   end
endmodule

// *** fsk_host_driver.sv ***
// Host end: writes 24-bit serial words and clocks audio step words out on the pins.
// Assumes a user that holds a request until its ready pulse; symbols pass straight on, except pin 0 while an audio frame is open.
`timescale 1ns/100ps
module fsk_host_driver
   import fsk_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   fsk_link_if.host link,
   input wire logic cmd_valid,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_data,
   output logic cmd_ready,
   input wire logic aud_valid,
   input wire logic [AUDIO_BITS-1:0] aud_data,
   output logic aud_ready,
   input wire logic [2:0] symbol,
   input wire logic txrx_level
);
   typedef enum logic [1:0] {IDLE, LOW, HIGH, DONE} eng_t;

   // Shared divider: both serial clocks change phase on the same tick
   logic [7:0] div, next_div;
   logic tick;
   assign tick = div == 8'(LINK_HALF_CYC - 1);

   eng_t s_st, next_s_st, a_st, next_a_st;
   logic [WORD_BITS-1:0] s_sh, next_s_sh;
   logic [AUDIO_BITS-1:0] a_sh, next_a_sh;
   logic [4:0] s_cnt, next_s_cnt, a_cnt, next_a_cnt;
   logic next_cmd_ready, next_aud_ready;
   logic next_ser_clk, next_ser_data, next_latch_n, next_mod_clk, next_mod_frame;
   logic [2:0] next_mod_data;
   logic next_txrx;

   always_comb begin
      next_div = tick ? 8'h00 : div + 8'h01;
      next_s_st = s_st;
      next_s_sh = s_sh;
      next_s_cnt = s_cnt;
      next_cmd_ready = 1'b0;
      next_ser_clk = link.ser_clk;
      next_ser_data = link.ser_data;
      next_latch_n = link.ser_latch_n;
      case (s_st)
         IDLE: if (cmd_valid && tick) begin
            // Reserved bits of the main word are the caller's to get right
            next_s_sh = {cmd_addr, cmd_data};
            next_s_cnt = 5'(WORD_BITS);
            next_latch_n = 1'b0;
            next_s_st = LOW;
         end
         LOW: if (tick) begin
            next_ser_data = s_sh[WORD_BITS-1];
            next_s_sh = {s_sh[WORD_BITS-2:0], 1'b0};
            next_ser_clk = 1'b0;
            next_s_st = HIGH;
         end
         HIGH: if (tick) begin
            next_ser_clk = 1'b1;
            next_s_cnt = s_cnt - 5'h01;
            next_s_st = s_cnt == 5'h01 ? DONE : LOW;
         end
         DONE: if (tick) begin
            next_ser_clk = 1'b0;
            next_latch_n = 1'b1;
            next_cmd_ready = 1'b1;
            next_s_st = IDLE;
         end
         default: next_s_st = IDLE;
      endcase

      next_a_st = a_st;
      next_a_sh = a_sh;
      next_a_cnt = a_cnt;
      next_aud_ready = 1'b0;
      next_mod_clk = link.mod_clk;
      next_mod_frame = link.mod_frame;
      next_mod_data = symbol;
      case (a_st)
         IDLE: if (aud_valid && tick) begin
            // Negative steps arrive already in two's complement
            next_a_sh = aud_data;
            next_a_cnt = 5'(AUDIO_BITS);
            next_mod_frame = 1'b1;
            next_a_st = LOW;
         end
         LOW: if (tick) begin
            next_a_sh = {a_sh[AUDIO_BITS-2:0], 1'b0};
            next_mod_clk = 1'b0;
            next_a_st = HIGH;
         end
         HIGH: if (tick) begin
            next_mod_clk = 1'b1;
            next_a_cnt = a_cnt - 5'h01;
            next_a_st = a_cnt == 5'h01 ? DONE : LOW;
         end
         DONE: if (tick) begin
            next_mod_clk = 1'b0;
            next_mod_frame = 1'b0;
            next_aud_ready = 1'b1;
            next_a_st = IDLE;
         end
         default: next_a_st = IDLE;
      endcase
      // While framing, pin 0 carries the serial step bits instead of the symbol
      if (a_st == LOW && tick) begin
         next_mod_data[0] = a_sh[AUDIO_BITS-1];
      end else if (a_st != IDLE) begin
         next_mod_data[0] = link.mod_data_pin[0];
      end
      next_txrx = txrx_level;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div <= '0;
         s_st <= IDLE;
         a_st <= IDLE;
         s_sh <= '0;
         a_sh <= '0;
         s_cnt <= '0;
         a_cnt <= '0;
         cmd_ready <= 1'b0;
         aud_ready <= 1'b0;
         link.ser_clk <= 1'b0;
         link.ser_data <= 1'b0;
         link.ser_latch_n <= 1'b1;
         link.mod_clk <= 1'b0;
         link.mod_frame <= 1'b0;
         link.mod_data_pin <= '0;
         link.txrx_control_pin <= 1'b0;
      end else begin
         div <= next_div;
         s_st <= next_s_st;
         a_st <= next_a_st;
         s_sh <= next_s_sh;
         a_sh <= next_a_sh;
         s_cnt <= next_s_cnt;
         a_cnt <= next_a_cnt;
         cmd_ready <= next_cmd_ready;
         aud_ready <= next_aud_ready;
         link.ser_clk <= next_ser_clk;
         link.ser_data <= next_ser_data;
         link.ser_latch_n <= next_latch_n;
         link.mod_clk <= next_mod_clk;
         link.mod_frame <= next_mod_frame;
         link.mod_data_pin <= next_mod_data;
         link.txrx_control_pin <= next_txrx;
      end
   end
endmodule

// *** fsk_link_sva.sv ***
// Checker for the serial and modulation wires between the host end and the device end.
// Assumes one clk domain; every wire is driven from a host flop.
`timescale 1ns/100ps
module fsk_link_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_latch_n,
   input wire logic txrx_control_pin,
   input wire logic [2:0] mod_data_pin,
   input wire logic mod_clk,
   input wire logic mod_frame
);
   logic [5:0] bit_cnt;
   logic [5:0] aud_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Counts restart when a frame opens, so a short or long word shows as a wrong total
   always_ff @(posedge clk) begin
      if (reset) begin
         bit_cnt <= 6'h00;
         aud_cnt <= 6'h00;
      end else begin
         bit_cnt <= $fell(ser_latch_n) ? 6'h00 : bit_cnt + 6'($rose(ser_clk));
         aud_cnt <= $rose(mod_frame) ? 6'h00 : aud_cnt + 6'($rose(mod_clk));
      end
   end
   ser_high_min_a: assert property ($rose(ser_clk) |=> ser_clk [*2])
      else $error("serial clock high phase too short");
   ser_low_min_a: assert property ($fell(ser_clk) |=> !ser_clk [*2])
      else $error("serial clock low phase too short");
   data_hold_a: assert property ($rose(ser_clk) |=> $stable(ser_data) [*2])
      else $error("serial data moved while clock high");
   clk_in_frame_a: assert property ($rose(ser_clk) |-> !ser_latch_n)
      else $error("serial clock edge outside a frame");
   word_bits_a: assert property ($rose(ser_latch_n) |-> bit_cnt == 6'd24)
      else $error("serial word not 24 bits");
   frame_length_a: assert property ($fell(ser_latch_n) |-> ##[400:600] $rose(ser_latch_n))
      else $error("serial frame did not close in time");
   audio_bits_a: assert property ($fell(mod_frame) |-> aud_cnt == 6'd16)
      else $error("audio word not 16 bits");
   mod_clk_frame_a: assert property ($rose(mod_clk) |-> mod_frame)
      else $error("audio clock edge outside a frame");
   audio_close_a: assert property ($fell(mod_frame) |-> !mod_clk)
      else $error("audio frame closed with clock high");
   audio_hold_a: assert property ($rose(mod_clk) |=> $stable(mod_data_pin[0]) [*2])
      else $error("audio data moved while clock high");
   cover property ($rose(ser_latch_n));
   cover property ($fell(mod_frame));
   cover property ($rose(txrx_control_pin));
   cover property ($changed(mod_data_pin));
endmodule

// *** tb.sv ***
// Testbench: host end and device end joined by the link interface.
// Assumes host user-side handshakes as described for the host driver.
`timescale 1ns/100ps
module tb
   import fsk_pkg::*;
;
   localparam logic [23:0] NA = 24'h123456;
   localparam logic [23:0] NB = 24'h0a0001;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = 8'h00;
   logic [DATA_W-1:0] cmd_data = 16'h0000;
   logic aud_valid = 1'b0;
   logic [AUDIO_BITS-1:0] aud_data = 16'h0000;
   logic [2:0] symbol = 3'h0;
   logic txrx_level = 1'b0;
   logic cmd_ready, aud_ready, active_profile, transmit_active, receive_active;
   logic cal_start, cal_dual;
   logic [NUM_W-1:0] freq_numerator;
   logic [DATA_W-1:0] main_control;
   logic [15:0] dev_a [8] = '{16'h0206, 16'h054d, 16'h068e, 16'hfab2, 16'hf971, 16'h0001,
      16'hffff, 16'h7fff};
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   int ncal = 0;
   int ndual = 0;
   int c0;
   fsk_link_if link();
   fsk_host_driver fsk_host_driver_inst (.clk(clk), .reset(reset), .link(link),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .aud_valid(aud_valid), .aud_data(aud_data), .aud_ready(aud_ready), .symbol(symbol),
      .txrx_level(txrx_level));
   fsk_profile_control fsk_profile_control_inst (.clk(clk), .reset(reset), .link(link),
      .freq_numerator(freq_numerator), .active_profile(active_profile),
      .transmit_active(transmit_active), .receive_active(receive_active),
      .cal_start(cal_start), .cal_dual(cal_dual), .main_control(main_control));
   fsk_link_sva fsk_link_sva_inst (.clk(clk), .reset(reset), .ser_clk(link.ser_clk),
      .ser_data(link.ser_data), .ser_latch_n(link.ser_latch_n),
      .txrx_control_pin(link.txrx_control_pin), .mod_data_pin(link.mod_data_pin),
      .mod_clk(link.mod_clk), .mod_frame(link.mod_frame));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cal_start === 1'b1) ncal++;
      if (cal_dual === 1'b1) ndual++;
      if (cycles == 40000) begin
         fails++;
         $display("[FAIL] %0t run did not finish", $time);
         end_of_test();
      end
   end
   function automatic logic [23:0] sx(input logic [15:0] d);
      return {{8{d[15]}}, d};
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask
   // One request on the command or audio side, held until its ready pulse is seen
   task automatic send(input logic is_aud, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cmd_valid <= !is_aud;
      aud_valid <= is_aud;
      cmd_addr <= a;
      cmd_data <= d;
      aud_data <= d;
      do begin
         @(posedge clk);
         n++;
      end while ((is_aud ? aud_ready : cmd_ready) !== 1'b1 && n < 700);
      cmd_valid <= 1'b0;
      aud_valid <= 1'b0;
      if (n >= 700) chk(1'b0, 1'b1, "no ready");
      settle();
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(main_control, 16'h0003, "main reset");
      chk({active_profile, transmit_active, receive_active}, 3'b010, "ports reset");
      chk(freq_numerator, 24'h0, "numerator reset");
      send(0, ADDR_NUM_A_HI, {8'h00, NA[23:16]});
      send(0, ADDR_NUM_A_LO, NA[15:0]);
      chk(main_control, 16'h0003, "main after reset");
      chk(freq_numerator, NA, "nominal");
      for (int i = 0; i < 8; i++) begin
         send(0, ADDR_DEV_A0 + 8'(i), dev_a[i]);
         send(0, ADDR_DEV_B0 + 8'(i), dev_a[i] ^ 16'h0f00);
      end
      send(0, ADDR_MOD_CTRL, 16'h001c);
      for (int i = 0; i < 8; i++) begin
         symbol <= 3'(i);
         settle();
         chk(freq_numerator, NA + sx(dev_a[i]), "pin mode");
      end
      send(0, ADDR_MOD_CTRL, 16'h0018);
      chk(freq_numerator, NA + sx(dev_a[3]), "four levels");
      send(0, ADDR_MOD_CTRL, 16'h0019);
      for (int i = 2; i < 6; i++) begin
         send(0, ADDR_DEV_SEL, 16'(i));
         chk(freq_numerator, NA + sx(dev_a[i % 4]), "select mode");
      end
      send(0, ADDR_MOD_CTRL, 16'h0013);
      send(0, ADDR_DIRECT, 16'hfab2);
      chk(freq_numerator, NA + sx(16'hfab2), "direct mode");
      send(0, ADDR_MOD_CTRL, 16'h0012);
      send(1, 8'h00, 16'hf971);
      chk(freq_numerator, NA + sx(16'hf971), "audio mode");
      send(0, ADDR_MOD_CTRL, 16'h0002);
      chk(freq_numerator, NA, "disabled");
      $display("test modulation done");
      send(0, ADDR_NUM_B_HI, {8'h00, NB[23:16]});
      send(0, ADDR_NUM_B_LO, NB[15:0]);
      send(0, ADDR_MAIN, 16'h0043);
      chk(active_profile, 1'b1, "profile b");
      chk(freq_numerator, NB, "profile b nominal");
      send(0, ADDR_MOD_CTRL, 16'h002c);
      chk(freq_numerator, NB + sx(16'h70ff), "profile b deviation");
      send(0, ADDR_MOD_CTRL, 16'h0000);
      $display("test profiles done");
      c0 = ncal;
      send(0, ADDR_MAIN, 16'h0002);
      chk(24'(ncal - c0), 24'd0, "no calibration");
      send(0, ADDR_MAIN, 16'h0003);
      chk(24'(ncal - c0), 24'd1, "calibration");
      c0 = ndual;
      send(0, ADDR_MAIN, 16'h0203);
      chk(24'(ndual - c0), 24'd1, "recalibrate both");
      send(0, ADDR_MAIN, 16'h0003);
      $display("test calibration done");
      send(0, ADDR_MAIN, 16'h0183);
      txrx_level <= 1'b1;
      settle();
      chk(active_profile, 1'b1, "pin swap");
      txrx_level <= 1'b0;
      settle();
      chk(active_profile, 1'b0, "pin swap back");
      send(0, ADDR_MAIN, 16'h0103);
      txrx_level <= 1'b1;
      settle();
      chk(active_profile, 1'b0, "swap needs dual");
      send(0, ADDR_MAIN, 16'h0803);
      chk({transmit_active, receive_active}, 2'b01, "low pol high pin");
      txrx_level <= 1'b0;
      settle();
      chk({transmit_active, receive_active}, 2'b10, "low pol low pin");
      send(0, ADDR_MAIN, 16'h0c03);
      chk(main_control, 16'h0c03, "main stored");
      chk({transmit_active, receive_active}, 2'b01, "high pol low pin");
      txrx_level <= 1'b1;
      settle();
      chk({transmit_active, receive_active}, 2'b10, "high pol high pin");
      send(0, ADDR_MAIN, 16'h2c43);
      chk(main_control, 16'h0003, "reset bit");
      chk(active_profile, 1'b0, "reset bit profile");
      c0 = ndual;
      send(0, ADDR_MAIN, 16'h0083);
      chk(24'(ndual - c0), 24'd1, "dual at first cal");
      send(0, ADDR_MAIN, 16'h0003);
      chk(24'(ndual - c0), 24'd1, "single cal after");
      $display("test switching done");
      end_of_test();
   end
endmodule
